// ==== hw/ltc_line_timer.sv ====
// Purpose: line trigger and exposure control with wishbone registers
// Assumes: trigger inputs synchronous to clk_i, classic wishbone master
// Notes: lamp is amber during initialization, green after
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "ltc_defines.svh"

// What this block does
// - amber lamp and initialization at power-up
// - green lamp once initialization is done
// - five trigger and exposure combinations supported
// - each qualified line trigger starts one line
// - timed triggers qualify on rise or fall
// - timed exposure never runs past next trigger
// - width mode exposes while trigger level active
// - exposure off exposes the full line
// - free run makes lines at programmed rate
// - free-run exposure never exceeds line period
// - blink green lamp while triggers arrive
module ltc_line_timer #(
    parameter int unsigned INIT_CYCLES = `LTC_INIT_CYCLES,
    parameter int unsigned BLINK_CYCLES = `LTC_BLINK_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`LTC_ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic [1:0] trig_i,
    output logic line_start_o,
    output logic exposure_o,
    output logic lamp_amber_o,
    output logic lamp_green_o,
    output logic init_done_o
);
    import ltc_pkg::*;

    ltc_line_if lnk ();

    // software settings
    logic [`LTC_CTRL_W-1:0] ctrl;
    ltc_cnt_t exposure;
    ltc_cnt_t period;
    logic cut_flag;
    logic [`LTC_LCNT_W-1:0] line_count;

    // sequencing and lamp state
    ltc_state_t state;
    ltc_state_t next_state;
    logic [`LTC_TMR_W-1:0] init_cnt;
    logic [`LTC_TMR_W-1:0] blink_cnt;
    logic [`LTC_TMR_W-1:0] activity_cnt;
    logic blink_phase;
    logic trig_prev;
    logic ack;
    logic [31:0] rdata;

    // named views of the control fields
    wire line_trigger_enable = ctrl[`LTC_CTRL_TRIG_EN];
    wire [1:0] mode_bits = ctrl[`LTC_CTRL_MODE_HI:`LTC_CTRL_MODE_LO];
    wire [1:0] qual_bits = ctrl[`LTC_CTRL_QUAL_HI:`LTC_CTRL_QUAL_LO];
    wire trigger_event_select = ctrl[`LTC_CTRL_EVT];
    wire trigger_input_select = ctrl[`LTC_CTRL_SRC];
    wire ltc_exp_mode_t exposure_control_select = ltc_exp_mode_t'(mode_bits);
    wire ltc_qual_t trigger_qualifier = ltc_qual_t'(qual_bits);
    wire running = (state == LTC_ST_RUN);

    // bus decode
    wire req = cyc_i & stb_i;
    wire wr_take = req & we_i & ack;
    wire hit_ctrl = (adr_i == `LTC_OFS_CTRL);
    wire hit_exposure = (adr_i == `LTC_OFS_EXPOSURE);
    wire hit_period = (adr_i == `LTC_OFS_PERIOD);
    wire hit_status = (adr_i == `LTC_OFS_STATUS);

    // byte-lane merge for the wide registers
    wire [31:0] exp_old = {{(32 - `LTC_CNT_W){1'b0}}, exposure};
    wire [31:0] per_old = {{(32 - `LTC_CNT_W){1'b0}}, period};
    wire [31:0] lane_mask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                             {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] exp_new = (exp_old & ~lane_mask) | (dat_i & lane_mask);
    wire [31:0] per_new = (per_old & ~lane_mask) | (dat_i & lane_mask);

    // trigger selection and qualification
    wire trig_level = trigger_input_select ? trig_i[1] : trig_i[0];
    wire trig_rise = trig_level & ~trig_prev;
    wire trig_fall = ~trig_level & trig_prev;
    wire level_low = (trigger_qualifier == LTC_QUAL_LOW);
    wire fall_qual = (trigger_qualifier == LTC_QUAL_FALL) | level_low;
    wire qual_edge = fall_qual ? trig_fall : trig_rise;
    // level qualifiers mark a line at the start of the active level
    wire trig_active = level_low ? ~trig_level : trig_level;
    // triggers before the end of initialization are dropped
    wire trig_ok = running & line_trigger_enable & trigger_event_select;
    wire trig_evt = qual_edge & trig_ok;

    // read data selection
    wire [31:0] stat_word = {line_count,
                             {(`LTC_STAT_CNT_LO - `LTC_STAT_CUT - 1){1'b0}},
                             cut_flag, lnk.exposing, running};
    wire [31:0] ctrl_word = {{(32 - `LTC_CTRL_W){1'b0}}, ctrl};
    wire [31:0] next_rdata = hit_ctrl ? ctrl_word :
                             hit_exposure ? exp_old :
                             hit_period ? per_old :
                             hit_status ? stat_word : 32'h0000_0000;

    // blink lamp only while triggers keep coming
    wire trig_seen = (activity_cnt != '0);
    wire blink_wrap = (blink_cnt >= BLINK_CYCLES - 1);

    // hand settings to the engine
    assign lnk.run = running;
    assign lnk.trig_mode = line_trigger_enable;
    assign lnk.exp_mode = exposure_control_select;
    assign lnk.exposure = exposure;
    assign lnk.period = period;
    assign lnk.trig_edge = trig_evt;
    assign lnk.trig_active = trig_active;

    ltc_line_engine u_engine (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lnk(lnk)
    );

    // power-up sequencing
    always_comb
    begin
        case (state)
            LTC_ST_INIT:
                if (init_cnt >= INIT_CYCLES - 1)
                    next_state = LTC_ST_RUN;
                else
                    next_state = LTC_ST_INIT;
            LTC_ST_RUN: next_state = LTC_ST_RUN;
            default: next_state = LTC_ST_INIT;
        endcase
    end

    // init timer; reset is the power-up event
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state <= LTC_ST_INIT;
            init_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            if (state == LTC_ST_INIT)
                init_cnt <= init_cnt + 1'b1;
        end
    end

    // bus answer: one wait cycle, ack drops after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end
        else
        begin
            ack <= req & ~ack;
            if (req & ~ack)
                rdata <= next_rdata;
        end
    end

    // setting registers, written at the edge that sees ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= `LTC_RST_CTRL;
            exposure <= `LTC_RST_EXPOSURE;
            period <= `LTC_RST_PERIOD;
        end
        else if (wr_take)
        begin
            if (hit_ctrl & sel_i[0])
                ctrl <= dat_i[`LTC_CTRL_W-1:0];
            if (hit_exposure)
                exposure <= exp_new[`LTC_CNT_W-1:0];
            if (hit_period)
                period <= per_new[`LTC_CNT_W-1:0];
        end
    end

    // sticky cut flag: write one to clear, a new cut wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cut_flag <= 1'b0;
        else if (lnk.cut)
            cut_flag <= 1'b1;
        else if (wr_take & hit_status & sel_i[0] & dat_i[`LTC_STAT_CUT])
            cut_flag <= 1'b0;
    end

    // line counter wraps; software reads it for progress only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            line_count <= '0;
        else if (lnk.line_start)
            line_count <= line_count + 1'b1;
    end

    // trigger history; tracked through init so a stale level gives no edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_level;
    end

    // activity window and blink phase, unrelated to trigger spacing
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            activity_cnt <= '0;
            blink_cnt <= '0;
            blink_phase <= 1'b0;
        end
        else
        begin
            if (trig_evt)
                activity_cnt <= BLINK_CYCLES;
            else if (trig_seen)
                activity_cnt <= activity_cnt - 1'b1;
            if (blink_wrap)
                blink_cnt <= '0;
            else
                blink_cnt <= blink_cnt + 1'b1;
            if (blink_wrap)
                blink_phase <= ~blink_phase;
        end
    end

    // lamp and pin outputs, all from flip-flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            lamp_amber_o <= 1'b1;
            lamp_green_o <= 1'b0;
            init_done_o <= 1'b0;
        end
        else
        begin
            lamp_amber_o <= ~running;
            lamp_green_o <= running
                & ~(line_trigger_enable & trig_seen & blink_phase);
            init_done_o <= running;
        end
    end

    assign line_start_o = lnk.line_start;
    assign exposure_o = lnk.exposing;
    assign ack_o = ack;
    assign dat_o = rdata;

endmodule : ltc_line_timer

// ==== hw/ltc_defines.svh ====
// Purpose: named offsets, fields, reset values and times of the line timer
// Assumes: 32-bit classic wishbone, 200 MHz core clock
// Notes: included by the package and by every design file
`ifndef LTC_DEFINES_SVH
`define LTC_DEFINES_SVH

// register byte offsets
`define LTC_ADR_W 8
`define LTC_OFS_CTRL 8'h00
`define LTC_OFS_EXPOSURE 8'h04
`define LTC_OFS_PERIOD 8'h08
`define LTC_OFS_STATUS 8'h0c

// control fields
`define LTC_CTRL_TRIG_EN 0
`define LTC_CTRL_MODE_LO 1
`define LTC_CTRL_MODE_HI 2
`define LTC_CTRL_QUAL_LO 3
`define LTC_CTRL_QUAL_HI 4
`define LTC_CTRL_EVT 5
`define LTC_CTRL_SRC 6
`define LTC_CTRL_W 7

// status fields
`define LTC_STAT_INIT 0
`define LTC_STAT_EXP 1
`define LTC_STAT_CUT 2
`define LTC_STAT_CNT_LO 16
`define LTC_STAT_CNT_HI 31
`define LTC_LCNT_W 16

// counter width for line period and exposure, in clock cycles
`define LTC_CNT_W 24

// reset values
`define LTC_RST_CTRL 7'h22
`define LTC_RST_EXPOSURE 24'h000100
`define LTC_RST_PERIOD 24'h0003e8

// times, as printed in their own units, and the clock rate
`define LTC_CLK_MHZ 200
`define LTC_INIT_TIME_US 1000
`define LTC_BLINK_TIME_MS 250
`define LTC_INIT_CYCLES (`LTC_INIT_TIME_US * `LTC_CLK_MHZ)
`define LTC_BLINK_CYCLES (`LTC_BLINK_TIME_MS * 1000 * `LTC_CLK_MHZ)
`define LTC_TMR_W 32

`endif

// ==== hw/ltc_pkg.sv ====
// Purpose: types and shared arithmetic of the line timer
// Assumes: defines header is on the include path
// Notes: mode encodings follow enum order
`include "ltc_defines.svh"

package ltc_pkg;

    // exposure control select: off, timed, pulse width
    typedef enum logic [1:0] {
        LTC_EXP_OFF,
        LTC_EXP_TIMED,
        LTC_EXP_WIDTH,
        LTC_EXP_RSVD
    } ltc_exp_mode_t;

    // trigger qualifier
    typedef enum logic [1:0] {
        LTC_QUAL_RISE,
        LTC_QUAL_FALL,
        LTC_QUAL_HIGH,
        LTC_QUAL_LOW
    } ltc_qual_t;

    // power-up sequencing
    typedef enum logic {
        LTC_ST_INIT,
        LTC_ST_RUN
    } ltc_state_t;

    typedef logic [`LTC_CNT_W-1:0] ltc_cnt_t;

    // true in the last cycle of a span of lim cycles; zero acts as one
    function automatic logic ltc_last(input ltc_cnt_t cnt, input ltc_cnt_t lim);
        ltc_last = (lim == '0) || (cnt >= lim - 1'b1);
    endfunction : ltc_last

endpackage : ltc_pkg

// ==== hw/ltc_line_if.sv ====
// Purpose: carrier between register side and line engine
// Assumes: one clock domain
// Notes: ctrl drives settings and trigger, engine answers
`timescale 1ns/10ps
`include "ltc_defines.svh"

interface ltc_line_if;
    import ltc_pkg::*;
    logic run;
    logic trig_mode;
    ltc_exp_mode_t exp_mode;
    ltc_cnt_t exposure;
    ltc_cnt_t period;
    logic trig_edge;
    logic trig_active;
    logic line_start;
    logic exposing;
    logic cut;

    modport ctrl (
        output run, trig_mode, exp_mode, exposure, period,
        output trig_edge, trig_active,
        input line_start, exposing, cut
    );
    modport engine (
        input run, trig_mode, exp_mode, exposure, period,
        input trig_edge, trig_active,
        output line_start, exposing, cut
    );
endinterface : ltc_line_if

// ==== hw/ltc_line_engine.sv ====
// Purpose: line start and exposure generation
// Assumes: trigger edge already qualified by the register side
// Notes: all outputs registered
`timescale 1ns/10ps
`include "ltc_defines.svh"

module ltc_line_engine (
    input wire logic clk_i,
    input wire logic rst_i,
    ltc_line_if.engine lnk
);
    import ltc_pkg::*;

    ltc_cnt_t line_cnt;
    ltc_cnt_t exp_cnt;
    logic started;
    logic exposing;
    logic next_exposing;
    wire free_start = lnk.run & ~lnk.trig_mode & ltc_last(line_cnt, lnk.period);
    wire trig_start = lnk.run & lnk.trig_mode & lnk.trig_edge;
    wire line_start_w = free_start | trig_start;
    wire exp_done = ltc_last(exp_cnt, lnk.exposure);

    // exposure level per mode
    always_comb
    begin
        case (lnk.exp_mode)
            LTC_EXP_OFF: next_exposing = lnk.run & (started | line_start_w);
            LTC_EXP_TIMED:
                if (line_start_w)
                    next_exposing = 1'b1;
                else
                    next_exposing = exposing & ~exp_done;
            LTC_EXP_WIDTH: next_exposing = lnk.run & lnk.trig_mode
                & lnk.trig_active & (started | line_start_w);
            default: next_exposing = 1'b0;
        endcase
    end

    // counters restart at every line start, so timed exposure never spans two lines
    always_ff @(posedge clk_i)
    begin
        if (rst_i || !lnk.run)
        begin
            line_cnt <= '0;
            exp_cnt <= '0;
            started <= 1'b0;
            exposing <= 1'b0;
            lnk.line_start <= 1'b0;
            lnk.cut <= 1'b0;
        end
        else
        begin
            line_cnt <= line_start_w ? '0 : line_cnt + 1'b1;
            exp_cnt <= line_start_w ? '0 : exp_cnt + 1'b1;
            started <= started | line_start_w;
            exposing <= next_exposing;
            lnk.line_start <= line_start_w;
            // a trigger cutting a running timed exposure is reported
            lnk.cut <= trig_start & exposing & ~exp_done
                & (lnk.exp_mode == LTC_EXP_TIMED);
        end
    end

    assign lnk.exposing = exposing;

endmodule : ltc_line_engine

// ==== verification/ltc_line_timer_assertions.sv ====
// Purpose: port-level checks of the line timer
// Assumes: ctrl is mirrored from acked wishbone writes
// Notes: bound to every ltc_line_timer instance
`timescale 1ns/10ps
`include "ltc_defines.svh"

module ltc_line_timer_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [`LTC_ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic [3:0] sel_i,
    input wire logic we_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic [1:0] trig_i,
    input wire logic line_start_o,
    input wire logic exposure_o,
    input wire logic lamp_amber_o,
    input wire logic lamp_green_o,
    input wire logic init_done_o
);
    import ltc_pkg::*;
    logic [6:0] ctrl;
    // decode of the mirrored control word
    wire logic wr_ctrl = cyc_i && stb_i && we_i && ack_o && sel_i[0]
        && adr_i == `LTC_OFS_CTRL;
    wire logic tg = ctrl[0] && ctrl[5] && init_done_o;
    wire logic [1:0] md = ctrl[2:1];
    wire logic [1:0] q = ctrl[4:3];
    wire logic t = trig_i[ctrl[6]];
    // mirror changes at the same edge the write lands
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl <= `LTC_RST_CTRL;
        else if (wr_ctrl)
            ctrl <= dat_i[6:0];
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_qual_edge;
        tg && md == LTC_EXP_TIMED
            && (q == LTC_QUAL_RISE ? $rose(t) : q == LTC_QUAL_FALL && $fell(t));
    endsequence
    sequence s_width_end;
        tg && md == LTC_EXP_WIDTH
            && (q == LTC_QUAL_HIGH ? $fell(t) : q == LTC_QUAL_LOW && $rose(t));
    endsequence
    property p_dark;
        !init_done_o |-> lamp_amber_o && !lamp_green_o;
    endproperty
    a_dark: assert property (p_dark)
        else $error("lamp not amber during init");
    property p_amber;
        init_done_o |-> !lamp_amber_o && lamp_green_o | ctrl[0];
    endproperty
    a_amber: assert property (p_amber)
        else $error("lamp not green after init");
    property p_hold;
        init_done_o |=> init_done_o;
    endproperty
    a_hold: assert property (p_hold)
        else $error("init done dropped");
    property p_quiet;
        !init_done_o |-> !line_start_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("line started during init");
    property p_qual;
        s_qual_edge |=> line_start_o;
    endproperty
    a_qual: assert property (p_qual)
        else $error("qualified edge gave no line");
    property p_width;
        s_width_end |=> !exposure_o;
    endproperty
    a_width: assert property (p_width)
        else $error("width exposure outlived level");
    property p_expose;
        line_start_o && md != LTC_EXP_RSVD |-> exposure_o;
    endproperty
    a_expose: assert property (p_expose)
        else $error("line start without exposure");
    property p_full;
        line_start_o && md == LTC_EXP_OFF |-> exposure_o [*4];
    endproperty
    a_full: assert property (p_full)
        else $error("off mode exposure broke");
    property p_steady;
        (init_done_o && !ctrl[0]) [*3] |-> lamp_green_o;
    endproperty
    a_steady: assert property (p_steady)
        else $error("lamp blinks in free run");
endmodule : ltc_line_timer_assertions

bind ltc_line_timer ltc_line_timer_assertions u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .trig_i(trig_i),
    .line_start_o(line_start_o), .exposure_o(exposure_o),
    .lamp_amber_o(lamp_amber_o), .lamp_green_o(lamp_green_o),
    .init_done_o(init_done_o)
);

// ==== verification/ltc_trig_src.sv ====
// Purpose: external line trigger source model
// Assumes: go sampled on a rising edge, settings held during a train
// Notes: inv gives an idle-high line for fall and low qualifiers
`timescale 1ns/10ps

module ltc_trig_src (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic inv_i,
    input wire logic line_i,
    input wire logic [7:0] hi_i,
    input wire logic [7:0] lo_i,
    input wire logic [7:0] cnt_i,
    output logic [1:0] trig_o,
    output logic busy_o
);
    logic act = 1'b0;
    logic nz = 1'b0;
    initial busy_o = 1'b0;
    // other line toggles in a train, so a wrong source pick shows
    always @(posedge clk_i)
        nz <= busy_o ? !nz : inv_i;
    assign trig_o = line_i ? {act ^ inv_i, nz} : {nz, act ^ inv_i};
    // one active pulse per line, period hi plus lo
    always
    begin
        @(posedge clk_i);
        if (go_i)
        begin
            busy_o <= 1'b1;
            repeat (cnt_i)
            begin
                act <= 1'b1;
                repeat (hi_i) @(posedge clk_i);
                act <= 1'b0;
                repeat (lo_i) @(posedge clk_i);
            end
            busy_o <= 1'b0;
        end
    end
endmodule : ltc_trig_src

// ==== verification/ltc_line_timer_tb_top.sv ====
// Purpose: self-checking bench of the line timer
// Assumes: short init and blink counts via parameters
// Notes: model counts lines and exposure cycles at every edge
`timescale 1ns/10ps
`include "ltc_defines.svh"

module ltc_line_timer_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr_i = '0;
    logic [31:0] dat_i = '0;
    logic [3:0] sel_i = '0;
    logic we_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic [31:0] dat_o, rd;
    logic ack_o, line_start_o, exposure_o, amber, green, done;
    logic go = 1'b0, inv = 1'b0, src = 1'b0, busy;
    logic [7:0] hi = 8'h01, lo = 8'h01, cnt = 8'h01;
    logic [1:0] trig;
    logic [15:0] b16;
    int n_mismatch = 0, num_checks = 0, seed = 58;
    int n_exp = 0, tcyc = 0, e, p, h, i0, k, x0, xd;
    bit blinked = 1'b0;
    int lt_q[$], le_q[$];

    always #2.5 clk_i = !clk_i;
    ltc_line_timer #(.INIT_CYCLES(64), .BLINK_CYCLES(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
        .dat_o(dat_o), .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .ack_o(ack_o), .trig_i(trig),
        .line_start_o(line_start_o), .exposure_o(exposure_o),
        .lamp_amber_o(amber), .lamp_green_o(green), .init_done_o(done));
    ltc_trig_src u_src (.clk_i(clk_i), .go_i(go), .inv_i(inv),
        .line_i(src), .hi_i(hi), .lo_i(lo), .cnt_i(cnt), .trig_o(trig),
        .busy_o(busy));
    // model side: line times and running exposure total
    always @(posedge clk_i)
    begin
        if (line_start_o === 1'b1)
        begin
            lt_q.push_back(tcyc);
            le_q.push_back(n_exp);
        end
        n_exp += (exposure_o === 1'b1);
        tcyc++;
        blinked |= done === 1'b1 && green === 1'b0;
    end

    task automatic chk(input logic [31:0] ex, input logic [31:0] act);
        num_checks++;
        if (act !== ex)
        begin
            n_mismatch++;
            $display("mismatch t=%0t exp=%h got=%h", $time, ex, act);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hf;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (n >= 50)
            n_mismatch++;
    endtask : wb

    // park the line with events off, then fire a train of n pulses
    task automatic train(input logic [6:0] c, input int l, input int n);
        wb(1'b1, `LTC_OFS_CTRL, {25'h0, c[6], 1'b0, c[4:0]});
        inv <= c[3];
        src <= c[6];
        hi <= 8'(h);
        lo <= 8'(l);
        cnt <= 8'(n);
        wb(1'b1, `LTC_OFS_CTRL, {25'h0, c});
        wb(1'b0, `LTC_OFS_STATUS, '0);
        b16 = rd[31:16] + 16'(n);
        @(negedge clk_i);
        x0 = n_exp;
        go <= 1'b1;
        @(negedge clk_i);
        go <= 1'b0;
        for (k = 0; k < 3000 && busy !== 1'b0; k++)
            @(negedge clk_i);
        repeat (16) @(negedge clk_i);
        xd = n_exp - x0;
        wb(1'b0, `LTC_OFS_STATUS, '0);
    endtask : train

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // main sequence
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `LTC_OFS_CTRL, '0);
        chk(`LTC_RST_CTRL, rd);
        wb(1'b1, 8'h10, $random(seed));
        wb(1'b0, 8'h10, '0);
        chk(32'h0, rd);
        h = 1;
        train(7'h23, 1, 3);
        chk(32'h0, rd);
        chk(32'h2, {amber, green});
        for (k = 0; k < 200 && done !== 1'b1; k++)
            @(negedge clk_i);
        chk(32'h1, {amber, green});
        for (int i = 0; i < 6; i++)
        begin
            e = 5 + $unsigned($random(seed)) % 6;
            p = i[1] ? e - 2 : e + 3;
            h = 1 + $unsigned($random(seed)) % (p - 1);
            wb(1'b1, `LTC_OFS_EXPOSURE, 32'(e));
            if (i < 4)
            begin
                train({i[0], 2'b10, i[0], 3'b011}, p - h, 6);
                chk({b16, 13'h0, i[1], 2'b01}, rd);
                chk((i[1] ? 5 * p : 5 * e) + e, xd);
                wb(1'b1, `LTC_OFS_STATUS, 32'h4);
            end
            else
            begin
                train({2'b01, 1'b1, i[0], 3'b101}, 4, 6);
                chk({b16, 16'h1}, rd);
                chk(6 * h, xd);
            end
        end
        chk(32'h1, blinked);
        h = 2;
        train(7'h21, 3, 4);
        chk({b16, 16'h3}, rd);
        x0 = n_exp;
        repeat (20) @(negedge clk_i);
        chk(20, n_exp - x0);
        for (int j = 0; j < 3; j++)
        begin
            p = 6 + $unsigned($random(seed)) % 5;
            e = j == 0 ? p - 2 : p + 3;
            wb(1'b1, `LTC_OFS_PERIOD, 32'(p));
            wb(1'b1, `LTC_OFS_EXPOSURE, 32'(e));
            wb(1'b1, `LTC_OFS_CTRL, j == 2 ? 32'h20 : 32'h22);
            @(negedge clk_i);
            i0 = lt_q.size() + 1;
            for (k = 0; k < 500 && lt_q.size() < i0 + 5; k++)
                @(negedge clk_i);
            chk(4 * p, lt_q[i0 + 4] - lt_q[i0]);
            chk(4 * (j == 0 ? e : p), le_q[i0 + 4] - le_q[i0]);
        end
        wrap_up();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        wrap_up();
    end
endmodule : ltc_line_timer_tb_top
